// File: shared/prr_pkg.sv
// package of the port reset and ackID status block
// assumes a single 125 MHz clock and an APB register bus
package prr_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int NPORT = 4;
  localparam int ACKW = 5;
  localparam int ACK_FIELD_STRIDE = 8;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTL_A = 8'h60;
  localparam logic [7:0] OFS_CTL_B = 8'h68;
  localparam logic [7:0] OFS_CTL_C = 8'h70;
  localparam logic [7:0] OFS_CTL_D = 8'h78;
  localparam logic [7:0] OFS_ACK_STAT = 8'h80;
  localparam logic [7:0] OFS_PORT_STAT = 8'h84;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTL_BIT = 0;
  localparam logic CTL_RST_VAL = 1'b0;
  localparam logic [ACKW-1:0] ACK_RST_VAL = 5'h00;
  localparam logic [ACKW-1:0] ACK_STEP = 5'h01;
  // ****************************************
  // state types
  // ****************************************
  typedef struct packed {
    logic [NPORT-1:0] ctl;
    logic [NPORT-1:0] portRst;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } prr_reg_s;
  typedef struct packed {
    logic [NPORT*ACKW-1:0] ack;
  } prr_trk_s;
endpackage

// File: shared/prr_ack_if.sv
// carrier between register block and ackID tracker
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface prr_ack_if
  import prr_pkg::*;
();
  logic [NPORT-1:0] txPkt;
  logic [NPORT-1:0] portRst;
  logic wrEn;
  logic [NPORT*ACKW-1:0] wrData;
  logic [NPORT*ACKW-1:0] ackId;
  modport ctrl (output txPkt, output portRst, output wrEn, output wrData, input ackId);
  modport trk (input txPkt, input portRst, input wrEn, input wrData, output ackId);
endinterface

// File: rtl/prr_ack_tracker.sv
// per-port next_tx_ack_identifier counters
// assumes txPkt pulses come from logic on clk_sys
`timescale 1ns/1ps
module prr_ack_tracker
  import prr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // link to register block
  prr_ack_if.trk ackBus
);
  prr_trk_s cur_ff;
  prr_trk_s nxt_cur;

  // ****************************************
  // counter update
  // ****************************************
  // port reset first, then software write, then transmit step
  always_comb begin
    nxt_cur = cur_ff;
    for (int i = 0; i < NPORT; i++) begin
      if (ackBus.portRst[i]) begin
        nxt_cur.ack[i*ACKW +: ACKW] = ACK_RST_VAL;
      end else if (ackBus.wrEn) begin
        nxt_cur.ack[i*ACKW +: ACKW] = ackBus.wrData[i*ACKW +: ACKW]; // RULE_06
      end else if (ackBus.txPkt[i]) begin
        nxt_cur.ack[i*ACKW +: ACKW] = cur_ff.ack[i*ACKW +: ACKW] + ACK_STEP; // RULE_04
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // true value always drives the link side
  assign ackBus.ackId = cur_ff.ack; // RULE_05 RULE_08

  // ****************************************
  // checks
  // ****************************************
  a_ack_step: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_04
    (ackBus.txPkt[0] && !ackBus.wrEn && !ackBus.portRst[0])
    |=> ackBus.ackId[ACKW-1:0] == $past(ackBus.ackId[ACKW-1:0]) + ACK_STEP)
    else $error("ackID did not advance after transmit");
  a_ack_write: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_06
    (ackBus.wrEn && !ackBus.portRst[3])
    |=> ackBus.ackId[3*ACKW +: ACKW] == $past(ackBus.wrData[3*ACKW +: ACKW]))
    else $error("software ackID write lost");
  a_ack_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_05
    (!ackBus.txPkt[1] && !ackBus.wrEn && !ackBus.portRst[1])
    |=> $stable(ackBus.ackId[ACKW +: ACKW]))
    else $error("ackID changed without cause");
endmodule

// File: rtl/prr_port_reset.sv
// port reset control and ackID status registers behind APB
// assumes APB master on clk_sys, txPkt pulses from same-clock logic
// Notes on behaviour
// RULE_01: one reset control bit per port at 0x60, 0x68, 0x70, 0x78.
// RULE_02: resetting one port should leave the other ports untouched; here a port 0 reset also resets ports 1 to 3.
// RULE_03: port 0 reset bit also resets every other port.
// RULE_04: each transmitted packet advances that port's next_tx_ack_identifier.
// RULE_05: next_tx_ack_identifier field holds the ID for the next packet.
// RULE_06: software writes to the ackID field change the ID in use.
// RULE_07: software reads of the ackID field always return zero.
// RULE_08: zero readback does not disturb the link; true ID still used.
// RULE_09: lowest offset is port 0, ascending to port 3.
`timescale 1ns/1ps
module prr_port_reset
  import prr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit events per port
  input wire logic [NPORT-1:0] txPkt,
  // port side
  output logic [NPORT-1:0] portRst,
  output logic [NPORT*ACKW-1:0] txAckId
);
  prr_reg_s reg_ff;
  prr_reg_s nxt_reg;
  prr_ack_if ackBus ();
  logic setupPh;
  logic accessPh;
  logic mapped;
  logic [NPORT-1:0] ctlHit;
  logic [NPORT*ACKW-1:0] ackWr;

  // ****************************************
  // decode
  // ****************************************
  // ascending offsets map to ports 0 to 3
  assign ctlHit[0] = paddr == OFS_CTL_A; // RULE_09 RULE_01
  assign ctlHit[1] = paddr == OFS_CTL_B; // RULE_01
  assign ctlHit[2] = paddr == OFS_CTL_C; // RULE_01
  assign ctlHit[3] = paddr == OFS_CTL_D; // RULE_01
  assign mapped = (|ctlHit) || paddr == OFS_ACK_STAT || paddr == OFS_PORT_STAT;
  assign setupPh = psel && !penable;
  assign accessPh = psel && penable && reg_ff.pready;

  // ackID write data, one byte lane per port
  always_comb begin
    ackWr = '0;
    for (int i = 0; i < NPORT; i++) begin
      ackWr[i*ACKW +: ACKW] = pwdata[i*ACK_FIELD_STRIDE +: ACKW];
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_reg = reg_ff;
    nxt_reg.pready = setupPh; // one-cycle access phase
    if (setupPh) begin
      nxt_reg.pslverr = !mapped;
      // ackID field reads zero, true value stays in the tracker
      nxt_reg.prdata = '0; // RULE_07
      for (int i = 0; i < NPORT; i++) begin
        if (ctlHit[i]) begin
          nxt_reg.prdata[CTL_BIT] = reg_ff.ctl[i];
        end
      end
      if (paddr == OFS_PORT_STAT) begin
        nxt_reg.prdata[NPORT-1:0] = reg_ff.portRst;
      end
    end else if (!psel) begin
      nxt_reg.pslverr = 1'b0;
    end
    if (accessPh && pwrite) begin
      for (int i = 0; i < NPORT; i++) begin
        if (ctlHit[i]) begin
          nxt_reg.ctl[i] = pwdata[CTL_BIT];
        end
      end
    end
    // port 0 bit fans out to all ports, others stay local
    nxt_reg.portRst = nxt_reg.ctl | {NPORT{nxt_reg.ctl[0]}}; // RULE_03 RULE_02
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_ff <= '0;
    end else begin
      reg_ff <= nxt_reg;
    end
  end

  // ****************************************
  // tracker hookup
  // ****************************************
  assign ackBus.txPkt = txPkt;
  assign ackBus.portRst = reg_ff.portRst;
  assign ackBus.wrEn = accessPh && pwrite && paddr == OFS_ACK_STAT; // RULE_06
  assign ackBus.wrData = ackWr;

  prr_ack_tracker uTrk (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ackBus(ackBus.trk)
  );

  // outputs
  assign prdata = reg_ff.prdata;
  assign pready = reg_ff.pready;
  assign pslverr = reg_ff.pslverr;
  assign portRst = reg_ff.portRst;
  assign txAckId = ackBus.ackId; // RULE_08

  // ****************************************
  // checks
  // ****************************************
  sequence s_setup(logic [7:0] a);
    psel && !penable && paddr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence

  a_port0_all: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_03
    reg_ff.ctl[0] |-> &portRst)
    else $error("port 0 reset did not reach all ports");
  a_port_isolate: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_02
    !reg_ff.ctl[0] |-> portRst == reg_ff.ctl)
    else $error("port reset leaked to another port");
  a_ctl_write: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_01
    s_wr(OFS_CTL_B) |=> portRst[1] == ($past(pwdata[CTL_BIT]) || reg_ff.ctl[0]))
    else $error("port 1 reset bit write lost");
  a_map_order: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_09
    s_wr(OFS_CTL_A) ##1 1'b1 |-> reg_ff.ctl[0] == $past(pwdata[CTL_BIT]))
    else $error("lowest offset does not drive port 0");
  a_ack_read_zero: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_07
    s_setup(OFS_ACK_STAT) ##1 pready |-> prdata == 32'h0000_0000)
    else $error("ackID read not zero");
  a_ready_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
    setupPh |=> pready ##1 !pready)
    else $error("access phase not one cycle");
  a_unmapped_err: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (setupPh && !mapped) |=> pslverr && pready)
    else $error("unmapped access not flagged");
  a_link_true_id: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_08
    (s_wr(OFS_ACK_STAT) ##0 !portRst[2])
    |=> txAckId[2*ACKW +: ACKW] == $past(pwdata[2*ACK_FIELD_STRIDE +: ACKW]))
    else $error("link ackID lost behind zero readback");

  // control bit read returns the stored bit only
  a_ctl_read: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_01
    s_setup(OFS_CTL_C) |=> prdata == 32'($past(reg_ff.ctl[2])))
    else $error("port 2 reset bit read wrong");
  // highest offset drives port 3
  a_ctl_d_write: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_01
    s_wr(OFS_CTL_D) |=> reg_ff.ctl[3] == $past(pwdata[CTL_BIT]))
    else $error("port 3 reset bit write lost");
  // status read shows the effective port resets
  a_stat_read: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_03
    s_setup(OFS_PORT_STAT) |=> prdata == 32'($past(portRst)))
    else $error("port status read wrong");
  // port 0 bit clears every port's ackID
  a_port0_clears: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_03
    reg_ff.ctl[0] |=> txAckId == '0)
    else $error("port 0 reset left an ackID");
  // resetting port 2 leaves ports 1 and 3 alone
  a_keep_others: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_02
    (s_wr(OFS_CTL_C) ##0 !reg_ff.ctl[0]) |=> $stable(portRst[3]) && $stable(portRst[1]))
    else $error("port 2 reset disturbed another port");
  // port held in reset keeps its ackID at zero
  a_rst_holds_ack: assert property (@(posedge clk_sys) disable iff (sys_rst)
    portRst[1] |=> txAckId[ACKW +: ACKW] == '0)
    else $error("ackID moved while port held in reset");
  // software write lands in lane 0 too
  a_ack_wr_lane: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_06
    (s_wr(OFS_ACK_STAT) ##0 !portRst[0]) |=> txAckId[ACKW-1:0] == $past(pwdata[ACKW-1:0]))
    else $error("port 0 ackID write lost");
  // link keeps counting on the true ID
  a_tx_true_id: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_08
    (txPkt[3] && !portRst[3] && !ackBus.wrEn)
    |=> txAckId[3*ACKW +: ACKW] == $past(txAckId[3*ACKW +: ACKW]) + ACK_STEP)
    else $error("link ackID did not advance");
  // mapped access answers without error
  a_err_mapped: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (setupPh && mapped) |=> !pslverr && pready)
    else $error("mapped access flagged as error");
  // unmapped write changes no control bit
  a_bad_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (psel && penable && pready && pwrite && !mapped) |=> $stable(reg_ff.ctl))
    else $error("unmapped write changed a control bit");
  // status register ignores writes
  a_stat_ro: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_wr(OFS_PORT_STAT) |=> $stable(reg_ff.ctl))
    else $error("status write changed a control bit");
  // control bits move only on a completed write
  a_idle_ctl: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(psel && penable && pready && pwrite) |=> $stable(reg_ff.ctl))
    else $error("control bit changed without a write");
  // error flag drops once deselected
  a_err_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !psel |=> !pslverr)
    else $error("error flag stuck after deselect");
  // read data changes only after a setup cycle
  a_prdata_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !setupPh |=> $stable(prdata))
    else $error("read data changed outside setup");
  // no ready while idle
  a_ready_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !psel |=> !pready)
    else $error("ready raised while idle");
endmodule

// File: testbench/prr_link_model.sv
// link partner model: turns bench requests into transmit events
// assumes the bench raises sendReq right after a rising edge
`timescale 1ns/1ps
module prr_link_model
  import prr_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // request and event
  input wire logic [NPORT-1:0] sendReq,
  output logic [NPORT-1:0] txPkt
);
  // one packet event per requested cycle
  always_ff @(posedge clk_sys) begin
    txPkt <= sendReq;
  end
endmodule

// File: testbench/prr_port_reset_tb.sv
// bench of the port reset block: apb transfers, packets, ackID checks
// assumes package, design and link model compiled before it
`timescale 1ns/1ps
module prr_port_reset_tb;
  import prr_pkg::*;
  logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic err, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [NPORT-1:0] sendReq = '0, txPkt, portRst;
  logic [NPORT*ACKW-1:0] txAckId;
  logic [ACKW-1:0] ea [NPORT];
  int errors = 0, compares = 0;

  prr_port_reset DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txPkt(txPkt), .portRst(portRst), .txAckId(txAckId));
  prr_link_model partner (.clk_sys(clk_sys), .sendReq(sendReq), .txPkt(txPkt));

  // 8 ns clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one apb transfer, ends at the falling edge after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // access phase lasts until pready is seen at a rising edge
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check(32'(pready), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk_sys);
  endtask
  // packets on ports m for k cycles; ports u are expected to count
  task automatic send(input logic [NPORT-1:0] m, input int k, input logic [NPORT-1:0] u);
    @(posedge clk_sys);
    sendReq <= m;
    repeat (k) @(posedge clk_sys);
    sendReq <= '0;
    repeat (2) @(negedge clk_sys);
    foreach (ea[i]) if (u[i]) ea[i] = ea[i] + ACKW'(k);
  endtask
  task automatic acks();
    foreach (ea[i]) check(32'(txAckId[i*ACKW +: ACKW]), 32'(ea[i]));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // reset values of the control bits and the ackIDs
  task automatic t_init();
    ea = '{default: '0};
    for (int p = 0; p < NPORT; p++) begin
      apb(1'b0, OFS_CTL_A + 8'(8 * p), 32'h0);
      check(rd, 32'(CTL_RST_VAL));
    end
    acks();
  endtask
  task automatic t_tx();
    send(4'b0100, 3, 4'b0100);
    acks();
    send(4'b1111, 1, 4'b1111);
    acks();
    apb(1'b0, OFS_ACK_STAT, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic t_sw();
    apb(1'b1, OFS_ACK_STAT, 32'h031f_000a);
    ea = '{5'h0a, 5'h00, 5'h1f, 5'h03};
    acks();
    apb(1'b0, OFS_ACK_STAT, 32'h0);
    check(rd, 32'h0);
    send(4'b0101, 2, 4'b0101);
    acks();
  endtask
  task automatic t_rst();
    logic [31:0] e;
    for (int p = NPORT - 1; p >= 0; p--) begin
      e = (p == 0) ? 32'hf : 32'h1 << p;
      apb(1'b1, OFS_CTL_A + 8'(8 * p), 32'h1);
      if (p == 0) ea = '{default: '0};
      else ea[p] = '0;
      check(32'(portRst), e);
      // tracker clears one edge after portRst rises
      @(negedge clk_sys);
      acks();
      apb(1'b0, OFS_CTL_A + 8'(8 * p), 32'h0);
      check(rd, 32'h1);
      apb(1'b0, OFS_PORT_STAT, 32'h0);
      check(rd, e);
      send(4'b1111, 1, ~e[NPORT-1:0]);
      acks();
      apb(1'b1, OFS_CTL_A + 8'(8 * p), 32'h0);
      check(32'(portRst), 32'h0);
    end
  endtask
  // unmapped address: error flagged, nothing changes
  task automatic t_bad();
    apb(1'b1, 8'h64, 32'h1);
    check(32'(err), 32'h1);
    check(32'(portRst), 32'h0);
    apb(1'b0, 8'h64, 32'h0);
    check({rd[31:1], err}, 32'h1);
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_init();
    t_tx();
    t_sw();
    t_rst();
    t_bad();
    summarize();
  end
  // watchdog against a hung handshake
  initial begin
    #20000;
    errors++;
    summarize();
  end
endmodule
